/* hdl/elec_cfg.svh */
// constants for the line event controller
`ifndef ELEC_CFG_SVH
`define ELEC_CFG_SVH
`define ELEC_NUM_LINES    28
`define ELEC_NUM_PINS     16
`define ELEC_ADDR_W       3
// register word indices (byte address = index * 4)
`define ELEC_IDX_IMASK    3'h0
`define ELEC_IDX_EMASK    3'h1
`define ELEC_IDX_RISE     3'h2
`define ELEC_IDX_FALL     3'h3
`define ELEC_IDX_SWTRIG   3'h4
`define ELEC_IDX_PEND     3'h5
// reset values
`define ELEC_IMASK_RST    28'hF940000
`define ELEC_ZERO_RST     28'h0000000
// lines that exist (18, 20, 24, 26 reserved)
`define ELEC_LINE_PRESENT 28'hAEBFFFF
// master bus offsets
`define ELEC_AHB_STATUS   32'h0000_0000
`define ELEC_AHB_WAKE     32'h0000_0004
`endif

/* hdl/elec_pkg.sv */
// types shared by both ends of the line event controller
package elec_pkg;
   typedef logic [27:0] elec_lines_t;
   typedef logic [2:0]  elec_addr_t;
endpackage

/* hdl/elec_if.sv */
// link between the line event controller and the core side
`timescale 1ns/100ps
`default_nettype none
interface elec_if;
   logic                 reg_wr;
   logic                 reg_rd;
   elec_pkg::elec_addr_t reg_addr;
   logic [27:0]          reg_wdata;
   logic [27:0]          reg_rdata;
   logic [27:0]          irq;
   logic                 event_pulse;
   modport dev  (input reg_wr, reg_rd, reg_addr, reg_wdata,
                 output reg_rdata, irq, event_pulse);
   modport core (output reg_wr, reg_rd, reg_addr, reg_wdata,
                 input reg_rdata, irq, event_pulse);
endinterface
`default_nettype wire

/* hdl/elec_device.sv */
// line event controller: device end
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "elec_cfg.svh"
// How it works
// RL1 - only selected edge directions fire a line
// RL2 - software sets trigger, mask, core channel
// RL3 - unmasked edge raises irq and pending
// RL4 - writing one clears pending; zero keeps
// RL5 - event use needs trigger and event enable
// RL6 - enabled edge gives one pulse, no pending
// RL7 - software trigger gives event pulse
// RL8 - software trigger sets pending and irq
// RL9 - irq lines reach core to wake it
// RL10 - event pulse drives core event input
// RL11 - event wake needs no pending clear
// RL12 - pend wake needs both pending clears
// RL13 - lines 0-15 from selected port pin
// RL14 - supply, alarm, tamper, comparators on lines
// RL15 - serial wakes on 23,25,27; others reserved
// RL16 - 28 lines, masks independent per line
// RL17 - rising and falling may combine
// RL18 - two-stage synchroniser before edge compare
// RL19 - edge wins over same-cycle pending clear
module elec_device #(
   parameter int NUM_LINES = `ELEC_NUM_LINES
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rstn_in,
   // line sources
   input  wire logic [15:0] port_pin_in,
   input  wire logic        supply_monitor_in,
   input  wire logic        rtc_alarm_in,
   input  wire logic        rtc_tamper_in,
   input  wire logic        comparator_a_in,
   input  wire logic        comparator_b_in,
   input  wire logic        two_wire_ctrl_a_in,
   input  wire logic        serial_port_a_in,
   input  wire logic        consumer_ctrl_bus_in,
   // core link
   elec_if.dev              bus
);
   import elec_pkg::*;

   initial begin
      if (NUM_LINES != `ELEC_NUM_LINES) $error("elec_device: only 28 lines supported");
   end

   // ==========================================================
   // line sources
   elec_lines_t raw_lines;
   always_comb begin
      raw_lines = '0;
      raw_lines[15:0] = port_pin_in;          // see RL13
      raw_lines[16] = supply_monitor_in;      // see RL14
      raw_lines[17] = rtc_alarm_in;
      raw_lines[19] = rtc_tamper_in;
      raw_lines[21] = comparator_a_in;
      raw_lines[22] = comparator_b_in;
      raw_lines[23] = two_wire_ctrl_a_in;     // see RL15
      raw_lines[25] = serial_port_a_in;
      raw_lines[27] = consumer_ctrl_bus_in;
   end

   // ==========================================================
   // synchroniser and edge detect
   elec_lines_t sync1_q, sync2_q, prev_q;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= raw_lines;               // see RL18
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // ==========================================================
   // configuration registers
   elec_lines_t imask_q, emask_q, rise_q, fall_q, pend_q, swtrig_q;
   logic wr_imask, wr_emask, wr_rise, wr_fall, wr_sw, wr_pend;
   assign wr_imask = bus.reg_wr && bus.reg_addr == `ELEC_IDX_IMASK;
   assign wr_emask = bus.reg_wr && bus.reg_addr == `ELEC_IDX_EMASK;
   assign wr_rise  = bus.reg_wr && bus.reg_addr == `ELEC_IDX_RISE;
   assign wr_fall  = bus.reg_wr && bus.reg_addr == `ELEC_IDX_FALL;
   assign wr_sw    = bus.reg_wr && bus.reg_addr == `ELEC_IDX_SWTRIG;
   assign wr_pend  = bus.reg_wr && bus.reg_addr == `ELEC_IDX_PEND;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         imask_q <= `ELEC_IMASK_RST;
         emask_q <= `ELEC_ZERO_RST;
         rise_q  <= `ELEC_ZERO_RST;
         fall_q  <= `ELEC_ZERO_RST;
      end else begin
         // independent per-line masks
         if (wr_imask) imask_q <= bus.reg_wdata & `ELEC_LINE_PRESENT;   // see RL16
         if (wr_emask) emask_q <= bus.reg_wdata & `ELEC_LINE_PRESENT;
         if (wr_rise)  rise_q  <= bus.reg_wdata & `ELEC_LINE_PRESENT;
         if (wr_fall)  fall_q  <= bus.reg_wdata & `ELEC_LINE_PRESENT;
      end
   end

   // ==========================================================
   // trigger and pending
   elec_lines_t hw_edge, sw_set, trig, pend_clr;
   // trigger register write hides an edge in that same cycle
   assign hw_edge = (wr_rise || wr_fall) ? '0 :
                    ((sync2_q & ~prev_q & rise_q) |
                     (~sync2_q & prev_q & fall_q));             // see RL1 see RL17
   assign sw_set   = wr_sw ? (bus.reg_wdata & ~swtrig_q & `ELEC_LINE_PRESENT) : '0;
   assign trig     = hw_edge | sw_set;
   assign pend_clr = wr_pend ? bus.reg_wdata : '0;               // see RL4

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_q <= `ELEC_ZERO_RST;
      end else begin
         // set wins over clear
         pend_q <= (pend_q & ~pend_clr) | (trig & imask_q);     // see RL3 see RL8 see RL19
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         swtrig_q <= `ELEC_ZERO_RST;
      end else begin
         // software bit stays set until its pending bit is cleared
         swtrig_q <= (swtrig_q & ~pend_clr) | sw_set;
      end
   end

   // ==========================================================
   // outputs
   elec_lines_t rdata_d;
   always_comb begin
      unique case (bus.reg_addr)
         `ELEC_IDX_IMASK:  rdata_d = imask_q;
         `ELEC_IDX_EMASK:  rdata_d = emask_q;
         `ELEC_IDX_RISE:   rdata_d = rise_q;
         `ELEC_IDX_FALL:   rdata_d = fall_q;
         `ELEC_IDX_SWTRIG: rdata_d = swtrig_q;
         `ELEC_IDX_PEND:   rdata_d = pend_q;
         default:          rdata_d = '0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus.reg_rdata   <= '0;
         bus.irq         <= '0;
         bus.event_pulse <= 1'b0;
      end else begin
         bus.reg_rdata   <= bus.reg_rd ? rdata_d : '0;
         // irq follows pending, pending never for event-only lines
         bus.irq         <= (pend_q & ~pend_clr) | (trig & imask_q);  // see RL9 see RL6
         bus.event_pulse <= |(trig & emask_q);                        // see RL6 see RL7 see RL10
      end
   end
endmodule
`default_nettype wire

/* hdl/elec_core.sv */
// core side: AHB-Lite slave bridging software to the line controller
`timescale 1ns/100ps
`default_nettype none
`include "elec_cfg.svh"
module elec_core (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // ahb-lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // core wake indications
   output logic             irq_any_out,
   output logic             wake_event_out,
   // link to device
   elec_if.core             bus
);
   import elec_pkg::*;

   // ==========================================================
   // address phase capture
   logic        dph_q, dwr_q, rd_wait_q, rd_wait2_q;
   logic [31:0] daddr_q;
   logic        take;
   assign take = hsel_in && hready_in && htrans_in[1];

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dph_q   <= 1'b0;
         dwr_q   <= 1'b0;
         daddr_q <= '0;
      end else if (hreadyout_out) begin
         dph_q   <= take;
         dwr_q   <= hwrite_in;
         daddr_q <= haddr_in;
      end
   end

   // ==========================================================
   // device access: 0x00..0x14 device words, 0x40 status
   logic dev_sel;
   assign dev_sel = daddr_q[31:6] == 26'h0 && daddr_q[4:2] <= 3'h5 && !daddr_q[5];
   always_comb begin
      bus.reg_wr    = dph_q && dwr_q && dev_sel && hreadyout_out;   // see RL2 see RL5
      // read strobe in the first wait cycle, while the address phase is still held
      bus.reg_rd    = dph_q && !dwr_q && dev_sel && rd_wait_q;
      bus.reg_addr  = daddr_q[4:2];
      bus.reg_wdata = hwdata_in[27:0];
   end

   // read needs two wait states: strobe, then the device's registered data
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_wait_q     <= 1'b0;
         rd_wait2_q    <= 1'b0;
         hreadyout_out <= 1'b1;
         hrdata_out    <= '0;
      end else begin
         rd_wait_q     <= take && !hwrite_in && hreadyout_out;
         rd_wait2_q    <= rd_wait_q;
         hreadyout_out <= !(take && !hwrite_in && hreadyout_out) && !rd_wait_q;
         if (rd_wait2_q) begin
            if (daddr_q[6])
               hrdata_out <= {30'h0, wake_event_out, irq_any_out};
            else
               hrdata_out <= {4'h0, bus.reg_rdata};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hresp_out      <= 1'b0;
         irq_any_out    <= 1'b0;
         wake_event_out <= 1'b0;
      end else begin
         hresp_out      <= 1'b0;
         irq_any_out    <= |bus.irq;                   // see RL9
         // sticky wake, cleared by a write to the status word; an event pulse in the same cycle wins
         if (bus.event_pulse)
            wake_event_out <= 1'b1;                    // see RL10
         else if (dph_q && dwr_q && daddr_q[6] && hreadyout_out)
            wake_event_out <= 1'b0;                    // see RL11
      end
   end
endmodule
`default_nettype wire

/* test/elec_asserts.sv */
// checker on the device-to-core link
`timescale 1ns/100ps
`default_nettype none
`include "elec_cfg.svh"
module elec_asserts (
   // clock and reset
   input wire logic                 clk_in,
   input wire logic                 rstn_in,
   // link
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire elec_pkg::elec_addr_t reg_addr,
   input wire logic [27:0]          reg_wdata,
   input wire logic [27:0]          reg_rdata,
   input wire logic [27:0]          irq,
   input wire logic                 event_pulse
);
   import elec_pkg::*;
   localparam logic [27:0] LIVE = `ELEC_LINE_PRESENT;
   logic [27:0] im_q, em_q, sw_q, swn_q;
   logic        wsw;
   assign wsw = reg_wr && reg_addr == `ELEC_IDX_SWTRIG;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ====================================
   // shadows; assume no two writes within two cycles
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         im_q <= `ELEC_IMASK_RST;
         em_q <= 28'h0;
         sw_q <= 28'h0;
         swn_q <= 28'h0;
      end else if (reg_wr) begin
         if (reg_addr == `ELEC_IDX_IMASK) im_q <= reg_wdata & LIVE;
         if (reg_addr == `ELEC_IDX_EMASK) em_q <= reg_wdata & LIVE;
         if (wsw) sw_q <= sw_q | reg_wdata;
         if (reg_addr == `ELEC_IDX_PEND) sw_q <= sw_q & ~reg_wdata;
         if (wsw) swn_q <= reg_wdata & im_q & ~sw_q & LIVE;
      end
   end
   // ====================================
   // properties
   property p_rsv; (irq & ~LIVE) == 28'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved line irq");
   property p_hold;
      ($past(irq) & ~irq & ~($past(reg_wdata)
         & {28{$past(reg_wr) && $past(reg_addr) == `ELEC_IDX_PEND}})) == 28'h0;
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   property p_clr;
      reg_wr && reg_addr == `ELEC_IDX_PEND |=> (irq & $past(reg_wdata)) == 28'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("pending not cleared");
   property p_open; (irq & ~$past(irq) & ~$past(im_q)) == 28'h0; endproperty
   a_open: assert property (p_open) else $error("masked irq set");
   property p_swi;
      wsw && (reg_wdata & im_q & ~sw_q & LIVE) != 28'h0 |-> ##[1:2] (irq & swn_q) == swn_q;
   endproperty
   a_swi: assert property (p_swi) else $error("sw irq missing");
   property p_swe;
      wsw && (reg_wdata & em_q & ~sw_q & LIVE) != 28'h0 |-> ##[1:3] event_pulse;
   endproperty
   a_swe: assert property (p_swe) else $error("sw event missing");
   property p_one; event_pulse |=> !event_pulse; endproperty
   a_one: assert property (p_one) else $error("long event pulse");
   property p_imr;
      reg_rd && reg_addr == `ELEC_IDX_IMASK |-> ##[1:2] reg_rdata == im_q;
   endproperty
   a_imr: assert property (p_imr) else $error("imask readback");
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for both ends
`timescale 1ns/100ps
`default_nettype none
`include "elec_cfg.svh"
module testbench;
   import elec_pkg::*;
   localparam logic [27:0] LIVE = `ELEC_LINE_PRESENT;
   logic        clk_in, rstn_in, hsel, hwrite, hrdy, hresp, irqa, wake;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [27:0] src;
   int          errors, cmp_count;
   elec_if bus ();
   elec_device i_elec_device (.clk_in(clk_in), .rstn_in(rstn_in), .port_pin_in(src[15:0]),
      .supply_monitor_in(src[16]), .rtc_alarm_in(src[17]), .rtc_tamper_in(src[19]),
      .comparator_a_in(src[21]), .comparator_b_in(src[22]), .two_wire_ctrl_a_in(src[23]),
      .serial_port_a_in(src[25]), .consumer_ctrl_bus_in(src[27]), .bus(bus));
   elec_core i_elec_core (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .irq_any_out(irqa), .wake_event_out(wake), .bus(bus));
   elec_asserts i_elec_asserts (.clk_in(clk_in), .rstn_in(rstn_in), .reg_wr(bus.reg_wr),
      .reg_rd(bus.reg_rd), .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
      .reg_rdata(bus.reg_rdata), .irq(bus.irq), .event_pulse(bus.event_pulse));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // ====================================
   // helpers
   task stop_test;
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // bounded wait for hready sampled high
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1) begin
         errors++;
         $display("[ERR] %0t bus hang", $time);
         stop_test;
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, d);
      @(posedge clk_in);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      rd = hrdata;
   endtask
   task wr(input logic [31:0] a, d);
      ahb(1'b1, a, d);
   endtask
   task rc(input logic [31:0] a, e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // sync plus edge logic needs under six cycles
   task pin(input int i, input logic v);
      @(posedge clk_in);
      src[i] <= v;
      repeat (6) @(posedge clk_in);
   endtask
   // ====================================
   // scenarios
   task s_sw;
      rc(32'h0, {4'h0, `ELEC_IMASK_RST});
      wr(32'h10, 32'h0080_0000);
      rc(32'h14, 32'h0080_0000);
      rc(32'h40, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      wr(32'h14, 32'h0);
      rc(32'h14, 32'h0080_0000);
      wr(32'h14, 32'h0080_0000);
      rc(32'h14, 32'h0);
      rc(32'h40, 32'h0);
   endtask
   task s_lines;
      wr(32'h0, {4'h0, LIVE});
      wr(32'h8, {4'h0, LIVE});
      for (int i = 0; i < 28; i++) begin
         if (LIVE[i]) begin
            pin(i, 1'b1);
            rc(32'h14, 32'h1 << i);
            wr(32'h14, 32'h1 << i);
            pin(i, 1'b0);
            rc(32'h14, 32'h0);
         end
      end
   endtask
   task s_both;
      wr(32'h8, 32'h2_0000);
      wr(32'hC, 32'h2_0000);
      pin(17, 1'b1);
      rc(32'h14, 32'h2_0000);
      wr(32'h14, 32'h2_0000);
      pin(17, 1'b0);
      rc(32'h14, 32'h2_0000);
      wr(32'h14, 32'h2_0000);
   endtask
   task s_evt;
      wr(32'h0, 32'h0);
      wr(32'h4, 32'h20_0000);
      wr(32'hC, 32'h20_0000);
      wr(32'h40, 32'h0);
      pin(21, 1'b1);
      pin(21, 1'b0);
      rc(32'h14, 32'h0);
      rc(32'h40, 32'h2);
      chk({30'h0, wake, irqa}, 32'h2);
      wr(32'h40, 32'h0);
      wr(32'h10, 32'h20_0000);
      rc(32'h40, 32'h2);
   endtask
   initial begin
      errors = 0;
      cmp_count = 0;
      src = 28'h0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rstn_in = 1'b0;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      s_sw;
      s_lines;
      s_both;
      s_evt;
      stop_test;
   end
endmodule
`default_nettype wire
